// ==== shared/lep_pkg.sv ====
// constants and types shared by the descriptor parser files
package lep_pkg;
    // register byte offsets on the avalon slave
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_POP = 6'h04;
    localparam logic [5:0] REG_STATUS = 6'h08;
    localparam logic [5:0] REG_LOGON = 6'h0C;
    localparam logic [5:0] REG_ECHO = 6'h10;
    localparam logic [5:0] REG_TSON = 6'h14;
    localparam logic [5:0] REG_SVNET = 6'h18;
    localparam logic [5:0] REG_MATCH = 6'h1C;
    // values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] POP_RST = 32'h0000_0000;
    // field positions, status and control bits
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_LINK_BIT = 0;
    localparam int ST_MATCH_BIT = 1;
    localparam int ST_ECHO_BIT = 2;
    localparam int ST_ARMED_BIT = 3;
    // body byte index of the last byte of each field, of the first byte of each list, and the RCS link type value
    localparam logic [7:0] LG_START_LO = 8'h01;
    localparam logic [7:0] LG_PERIOD_LO = 8'h03;
    localparam logic [7:0] LG_COUNT = 8'h04;
    localparam logic [7:0] LG_ID_BASE = 8'h05;
    localparam logic [7:0] EC_VALUE_LO = 8'h01;
    localparam logic [7:0] LK_TS_LO = 8'h01;
    localparam logic [7:0] LK_ON_LO = 8'h03;
    localparam logic [7:0] LK_SV_LO = 8'h05;
    localparam logic [7:0] LK_TYPE = 8'h06;
    localparam logic [7:0] LK_NET_LO = 8'h08;
    localparam logic [7:0] LK_RCNT = 8'h09;
    localparam logic [7:0] LK_PAIR_BASE = 8'h0A;
    localparam logic [7:0] LINK_TYPE_RCS = 8'h81;
    // byte walker states
    typedef enum logic [1:0] {
        ST_TAG = 2'b00,
        ST_LEN = 2'b01,
        ST_BODY = 2'b10
    } lep_state_t;
    // which descriptor the body belongs to
    typedef enum logic [1:0] {
        KD_SKIP = 2'b00,
        KD_LOGON = 2'b01,
        KD_ECHO = 2'b10,
        KD_LINK = 2'b11
    } lep_kind_t;
endpackage : lep_pkg

// ==== design/lep_range_match.sv ====
// population range matcher with sticky hit and captured network label
module lep_range_match (
    input logic clock,
    input logic sys_rst,
    input logic clr,
    input logic pair_valid,
    input logic [15:0] range_base,
    input logic [15:0] range_dont_care,
    input logic [15:0] pop_id,
    input logic [15:0] label,
    output logic hit_r,
    output logic [15:0] label_r
);
    // bits with a one in the don't-care word never take part
    function automatic logic pop_hit(input logic [15:0] b, input logic [15:0] m,
                                     input logic [15:0] p);
        pop_hit = (((b ^ p) & ~m) == 16'h0000);
    endfunction : pop_hit

    wire now_hit = pair_valid & pop_hit(range_base, range_dont_care, pop_id);

    // a hit in the clearing cycle is kept, set wins over clear
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            hit_r <= 1'b0;
            label_r <= 16'h0000;
        end
        else
        begin
            hit_r <= now_hit | (hit_r & ~clr);
            if (now_hit)
                label_r <= label;
        end
    end
endmodule : lep_range_match

// ==== design/lep_logon_sched.sv ====
// future logon identifier store and superframe scheduler
module lep_logon_sched #(
    parameter int DEPTH = 256
) (
    input logic clock,
    input logic sys_rst,
    input logic wr_en,
    input logic [7:0] wr_addr,
    input logic [15:0] wr_data,
    input logic load,
    input logic [15:0] start,
    input logic [15:0] period,
    input logic [7:0] last,
    input logic sf_tick,
    input logic [15:0] sf_count,
    output logic [15:0] active_id_r,
    output logic id_update_r,
    output logic armed_r
);
    logic [15:0] ids [0:DEPTH-1];
    logic [7:0] next_idx_r;
    logic [15:0] next_sf_r;
    logic [7:0] last_r;

    wire due = armed_r & sf_tick & (sf_count == next_sf_r);
    // a fresh list disarms the old one unless an entry falls due in that cycle; its entries are being overwritten
    wire disarm = wr_en & (wr_addr == 8'h00);

    always_ff @(posedge clock)
    begin
        if (wr_en)
            ids[wr_addr] <= wr_data;
    end

    // first entry at the start count, then one period per entry
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            armed_r <= 1'b0;
            next_idx_r <= 8'h00;
            next_sf_r <= 16'h0000;
            last_r <= 8'h00;
            active_id_r <= 16'h0000;
            id_update_r <= 1'b0;
        end
        else
        begin
            id_update_r <= due;
            if (load)
            begin
                armed_r <= 1'b1;
                next_idx_r <= 8'h00;
                next_sf_r <= start;
                last_r <= last;
            end
            else if (due)
            begin
                active_id_r <= ids[next_idx_r];
                armed_r <= (next_idx_r != last_r);
                next_idx_r <= next_idx_r + 8'h01;
                next_sf_r <= next_sf_r + period;
            end
            else if (disarm)
                armed_r <= 1'b0;
        end
    end
endmodule : lep_logon_sched

// ==== design/lep_parser.sv ====
// descriptor walker: logon schedule, echo value and linkage ranges
// What this block does
// - a descriptor is a tag byte, then a length of the bytes after it.
// - fields fill whole lines; there are no reserved bits to drop.
// - the schedule comes only from a decrypted terminal-keyed message.
// - schedule: start, period, entry count, then identifiers in order.
// - the entry count is one less than the identifier count.
// - the first identifier takes effect when the superframe count hits start.
// - each later identifier takes effect one period after the previous.
// - a received echo value is handed back for the return bytes.
// - linkage extension fields are taken in fixed order.
// - count-plus-one base and mask pairs follow, then private bytes.
// - the population id matches where it equals the base on cared-for bits.
// - apart from clearing the private byte count, the extension is used only for the return-link signalling type.
module lep_parser #(
    parameter logic [7:0] TAG_LOGON = 8'hA0,
    parameter logic [7:0] TAG_ECHO = 8'hA1,
    parameter logic [7:0] TAG_LINK = 8'hA2,
    parameter int SCHED_DEPTH = 256
) (
    input logic clock,
    input logic sys_rst,
    input logic [5:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input logic desc_valid,
    input logic [7:0] desc_data,
    input logic desc_first,
    input logic desc_secure,
    input logic sf_tick,
    input logic [15:0] sf_count,
    output logic [15:0] logon_id,
    output logic logon_update,
    output logic logon_armed,
    output logic [15:0] echo_word,
    output logic echo_pending,
    input logic echo_ack,
    output logic net_match,
    output logic [15:0] net_label,
    output logic priv_valid,
    output logic [7:0] priv_data
);
    // byte-enable merge, shared by both writable registers
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        be_merge = r;
    endfunction : be_merge

    lep_pkg::lep_state_t st_r;
    lep_pkg::lep_state_t st_nxt;
    lep_pkg::lep_kind_t kind_r;
    lep_pkg::lep_kind_t kind_nxt;
    logic [7:0] len_r;
    logic [7:0] idx_r;
    logic [7:0] hold_r;
    logic [31:0] ctrl_r;
    logic [31:0] pop_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [15:0] lg_start_r;
    logic [15:0] lg_period_r;
    logic [7:0] lg_count_r;
    logic [7:0] lg_last_r;
    logic lg_any_r;
    logic [15:0] echo_r;
    logic echo_pend_r;
    logic [15:0] ts_stage_r;
    logic [15:0] on_stage_r;
    logic [15:0] sv_stage_r;
    logic [15:0] net_stage_r;
    logic [7:0] type_r;
    logic [15:0] ts_r;
    logic [15:0] on_r;
    logic [15:0] sv_r;
    logic [15:0] net_r;
    logic link_ok_r;
    logic [8:0] pairs_left_r;
    logic [1:0] pb_r;
    logic [23:0] pair_sr_r;
    logic pair_valid_r;
    logic [31:0] pair_word_r;
    logic [7:0] priv_cnt_r;
    logic priv_valid_r;
    logic [7:0] priv_data_r;
    logic [15:0] sched_id;
    logic sched_upd;
    logic sched_armed;
    logic hit;
    logic [15:0] hit_label;

    // byte classification; a first-byte mark always restarts at a tag
    wire take = desc_valid & ctrl_r[lep_pkg::CTRL_EN_BIT];
    wire is_tag = take & (desc_first | (st_r == lep_pkg::ST_TAG));
    wire is_len = take & ~desc_first & (st_r == lep_pkg::ST_LEN);
    wire is_body = take & ~desc_first & (st_r == lep_pkg::ST_BODY);
    wire body_last = is_body & (idx_r == len_r - 8'h01);
    wire [15:0] word16 = {hold_r, desc_data};

    // tag, length, then exactly length body bytes
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            lep_pkg::ST_TAG:
                if (is_tag)
                    st_nxt = lep_pkg::ST_LEN;
            lep_pkg::ST_LEN:
                if (is_tag)
                    st_nxt = lep_pkg::ST_LEN;
                else if (is_len)
                    st_nxt = (desc_data == 8'h00) ? lep_pkg::ST_TAG
                                                  : lep_pkg::ST_BODY;
            lep_pkg::ST_BODY:
                if (is_tag)
                    st_nxt = lep_pkg::ST_LEN;
                else if (body_last)
                    st_nxt = lep_pkg::ST_TAG;
            default:
                st_nxt = lep_pkg::ST_TAG;
        endcase
    end

    // unknown tags skip; schedule needs decryption
    always_comb
    begin
        kind_nxt = lep_pkg::KD_SKIP;
        if (desc_data == TAG_LOGON && desc_secure)
            kind_nxt = lep_pkg::KD_LOGON;
        else if (desc_data == TAG_ECHO)
            kind_nxt = lep_pkg::KD_ECHO;
        else if (desc_data == TAG_LINK)
            kind_nxt = lep_pkg::KD_LINK;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_r <= lep_pkg::ST_TAG;
            kind_r <= lep_pkg::KD_SKIP;
            len_r <= 8'h00;
            idx_r <= 8'h00;
            hold_r <= 8'h00;
        end
        else
        begin
            st_r <= st_nxt;
            if (is_tag)
                kind_r <= kind_nxt;
            if (is_len)
                len_r <= desc_data;
            if (is_len)
                idx_r <= 8'h00;
            else if (is_body)
                idx_r <= idx_r + 8'h01;
            if (is_body)
                hold_r <= desc_data;
        end
    end

    // logon schedule fields; every field is a whole line, no reserved bits
    wire lg = is_body & (kind_r == lep_pkg::KD_LOGON);
    wire [7:0] id_off = idx_r - lep_pkg::LG_ID_BASE;
    wire id_wr = lg & (idx_r >= lep_pkg::LG_ID_BASE) & id_off[0]
                 & ({1'b0, id_off[7:1]} <= lg_count_r);
    wire lg_load = lg & body_last & (lg_any_r | id_wr);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            lg_start_r <= 16'h0000;
            lg_period_r <= 16'h0000;
            lg_count_r <= 8'h00;
            lg_last_r <= 8'h00;
            lg_any_r <= 1'b0;
        end
        else
        begin
            if (lg & idx_r == lep_pkg::LG_START_LO)
                lg_start_r <= word16;
            if (lg & idx_r == lep_pkg::LG_PERIOD_LO)
                lg_period_r <= word16;
            if (lg & idx_r == lep_pkg::LG_COUNT)
                lg_count_r <= desc_data;
            if (id_wr)
                lg_last_r <= {1'b0, id_off[7:1]};
            if (is_tag)
                lg_any_r <= 1'b0;
            else if (id_wr)
                lg_any_r <= 1'b1;
        end
    end

    // a truncated list arms only the identifiers actually received
    lep_logon_sched #(
        .DEPTH(SCHED_DEPTH)
    ) u_sched (
        .clock(clock),
        .sys_rst(sys_rst),
        .wr_en(id_wr),
        .wr_addr({1'b0, id_off[7:1]}),
        .wr_data(word16),
        .load(lg_load),
        .start(lg_start_r),
        .period(lg_period_r),
        .last(id_wr ? {1'b0, id_off[7:1]} : lg_last_r),
        .sf_tick(sf_tick),
        .sf_count(sf_count),
        .active_id_r(sched_id),
        .id_update_r(sched_upd),
        .armed_r(sched_armed)
    );

    // echo value waits for the burst builder; new value beats the ack
    wire ec_set = is_body & (kind_r == lep_pkg::KD_ECHO)
                  & (idx_r == lep_pkg::EC_VALUE_LO);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            echo_r <= 16'h0000;
            echo_pend_r <= 1'b0;
        end
        else
        begin
            if (ec_set)
                echo_r <= word16;
            echo_pend_r <= ec_set | (echo_pend_r & ~echo_ack);
        end
    end

    // linkage fields staged until descriptor end
    wire lk = is_body & (kind_r == lep_pkg::KD_LINK);
    wire lk_tail = lk & (idx_r >= lep_pkg::LK_PAIR_BASE);
    wire rcs_type = (type_r == lep_pkg::LINK_TYPE_RCS);
    wire pair_byte = lk_tail & (pairs_left_r != 9'h000);
    wire priv_byte = lk_tail & (pairs_left_r == 9'h000) & rcs_type;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ts_stage_r <= 16'h0000;
            on_stage_r <= 16'h0000;
            sv_stage_r <= 16'h0000;
            net_stage_r <= 16'h0000;
            type_r <= 8'h00;
        end
        else
        begin
            if (lk & idx_r == lep_pkg::LK_TS_LO)
                ts_stage_r <= word16;
            if (lk & idx_r == lep_pkg::LK_ON_LO)
                on_stage_r <= word16;
            if (lk & idx_r == lep_pkg::LK_SV_LO)
                sv_stage_r <= word16;
            if (lk & idx_r == lep_pkg::LK_TYPE)
                type_r <= desc_data;
            else if (is_tag)
                type_r <= 8'h00;
            if (lk & idx_r == lep_pkg::LK_NET_LO)
                net_stage_r <= word16;
        end
    end

    // range pairs: four bytes each, base first, then don't-care mask
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pairs_left_r <= 9'h000;
            pb_r <= 2'b00;
            pair_sr_r <= 24'h00_0000;
            pair_valid_r <= 1'b0;
            pair_word_r <= 32'h0000_0000;
        end
        else
        begin
            pair_valid_r <= pair_byte & (pb_r == 2'b11) & rcs_type;
            if (is_tag)
                pairs_left_r <= 9'h000;
            else if (lk & idx_r == lep_pkg::LK_RCNT)
                pairs_left_r <= {1'b0, desc_data} + 9'h001;
            else if (pair_byte & pb_r == 2'b11)
                pairs_left_r <= pairs_left_r - 9'h001;
            if (is_tag | (lk & idx_r == lep_pkg::LK_RCNT))
                pb_r <= 2'b00;
            else if (pair_byte)
                pb_r <= pb_r + 2'b01;
            if (pair_byte)
                pair_sr_r <= {pair_sr_r[15:0], desc_data};
            if (pair_byte & pb_r == 2'b11)
                pair_word_r <= {pair_sr_r, desc_data};
        end
    end

    // matching is gated off for any other linkage type
    lep_range_match u_match (
        .clock(clock),
        .sys_rst(sys_rst),
        .clr(take & desc_first),
        .pair_valid(pair_valid_r),
        .range_base(pair_word_r[31:16]),
        .range_dont_care(pair_word_r[15:0]),
        .pop_id(pop_r[15:0]),
        .label(net_stage_r),
        .hit_r(hit),
        .label_r(hit_label)
    );

    // private bytes, then linkage commit
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            priv_valid_r <= 1'b0;
            priv_data_r <= 8'h00;
            priv_cnt_r <= 8'h00;
            ts_r <= 16'h0000;
            on_r <= 16'h0000;
            sv_r <= 16'h0000;
            net_r <= 16'h0000;
            link_ok_r <= 1'b0;
        end
        else
        begin
            priv_valid_r <= priv_byte;
            if (priv_byte)
                priv_data_r <= desc_data;
            if (lk & idx_r == lep_pkg::LK_RCNT)
                priv_cnt_r <= 8'h00;
            else if (priv_byte)
                priv_cnt_r <= priv_cnt_r + 8'h01;
            if (lk & body_last & rcs_type)
            begin
                ts_r <= ts_stage_r;
                on_r <= on_stage_r;
                sv_r <= sv_stage_r;
                net_r <= net_stage_r;
                link_ok_r <= 1'b1;
            end
        end
    end

    // avalon slave: one wait state, write lands on the released edge
    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ~wait_r;
    wire [31:0] status_w = {28'h000_0000, sched_armed, echo_pend_r, hit,
                            link_ok_r};
    wire [31:0] rd_mux =
        (avs_address == lep_pkg::REG_CTRL) ? ctrl_r :
        (avs_address == lep_pkg::REG_POP) ? pop_r :
        (avs_address == lep_pkg::REG_STATUS) ? status_w :
        (avs_address == lep_pkg::REG_LOGON) ? {16'h0000, sched_id} :
        (avs_address == lep_pkg::REG_ECHO) ? {16'h0000, echo_r} :
        (avs_address == lep_pkg::REG_TSON) ? {ts_r, on_r} :
        (avs_address == lep_pkg::REG_SVNET) ? {sv_r, net_r} :
        (avs_address == lep_pkg::REG_MATCH) ? {8'h00, priv_cnt_r, hit_label} :
        32'h0000_0000;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= lep_pkg::CTRL_RST;
            pop_r <= lep_pkg::POP_RST;
        end
        else
        begin
            wait_r <= ~(req & wait_r);
            if (avs_read & wait_r)
                rdata_r <= rd_mux;
            if (wr_go & avs_address == lep_pkg::REG_CTRL)
                ctrl_r <= be_merge(ctrl_r, avs_writedata, avs_byteenable)
                          & 32'h0000_0001;
            if (wr_go & avs_address == lep_pkg::REG_POP)
                pop_r <= be_merge(pop_r, avs_writedata, avs_byteenable)
                         & 32'h0000_FFFF;
        end
    end

    // outputs straight from flops
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign logon_id = sched_id;
    assign logon_update = sched_upd;
    assign logon_armed = sched_armed;
    assign echo_word = echo_r;
    assign echo_pending = echo_pend_r;
    assign net_match = hit;
    assign net_label = hit_label;
    assign priv_valid = priv_valid_r;
    assign priv_data = priv_data_r;
endmodule : lep_parser

// ==== verif/lep_parser_monitor.sv ====
// port-level checks of the descriptor walker
module lep_parser_monitor (
    input logic clock,
    input logic sys_rst,
    input logic [5:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic desc_valid,
    input logic desc_first,
    input logic sf_tick,
    input logic [15:0] logon_id,
    input logic logon_update,
    input logic logon_armed,
    input logic [15:0] echo_word,
    input logic echo_pending,
    input logic echo_ack,
    input logic net_match,
    input logic priv_valid
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // one wait state, one answer cycle
    property p_wait_ans;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("late answer");
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("long answer");
    property p_rd_zero;
        avs_read && !avs_waitrequest && avs_address > lep_pkg::REG_MATCH
            |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unmapped read");
    // echo flag only falls on an acknowledge
    property p_echo_hold;
        echo_pending && !echo_ack |=> echo_pending;
    endproperty
    a_echo_hold: assert property (p_echo_hold) else $error("echo lost");
    property p_echo_clr;
        echo_pending && echo_ack && !desc_valid |=> !echo_pending;
    endproperty
    a_echo_clr: assert property (p_echo_clr) else $error("echo stuck");
    property p_echo_new;
        !$stable(echo_word) |-> echo_pending;
    endproperty
    a_echo_new: assert property (p_echo_new) else $error("echo silent");
    // ids move only on an armed tick
    property p_upd_tick;
        logon_update |-> $past(sf_tick) && $past(logon_armed);
    endproperty
    a_upd_tick: assert property (p_upd_tick) else $error("stray update");
    property p_id_upd;
        !$stable(logon_id) |-> logon_update;
    endproperty
    a_id_upd: assert property (p_id_upd) else $error("id moved");
    property p_priv_byte;
        priv_valid |-> $past(desc_valid);
    endproperty
    a_priv_byte: assert property (p_priv_byte) else $error("no byte");
    property p_match_stick;
        net_match && !(desc_valid && desc_first) |=> net_match;
    endproperty
    a_match_stick: assert property (p_match_stick) else $error("hit lost");
endmodule : lep_parser_monitor

// ==== verif/lep_fl_source.sv ====
// forward-link section filter model
module lep_fl_source (
    input wire logic clock,
    output logic desc_valid,
    output logic [7:0] desc_data,
    output logic desc_first,
    output logic desc_secure
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] q[$];
    logic slow = 1'b0;
    // entries are {secure, first, byte}; the bench frames them
    task automatic push(input logic [9:0] e);
        q.push_back(e);
    endtask : push
    initial
    begin
        {desc_valid, desc_first, desc_secure, desc_data} = 11'h000;
    end
    // slow mode leaves a gap after every byte
    always @(posedge clock)
    begin
        if (q.size() != 0 && !(slow && desc_valid))
        begin
            {desc_secure, desc_first, desc_data} <= q.pop_front();
            desc_valid <= 1'b1;
        end
        else
        begin
            desc_valid <= 1'b0;
            desc_first <= 1'b0;
            desc_data <= ~desc_data; // no stale byte on an idle line
        end
    end
endmodule : lep_fl_source

// ==== verif/lep_parser_test.sv ====
// self-checking bench for the descriptor walker
module lep_parser_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic desc_valid, desc_first, desc_secure, sf_tick, echo_ack;
    logic [7:0] desc_data, priv_data;
    logic [15:0] sf_count, logon_id, echo_word, net_label;
    logic logon_update, logon_armed, echo_pending, net_match, priv_valid;
    logic [3:0] avs_byteenable = 4'hF;
    int fail_count = 0;
    int total_checks = 0;
    int priv_n = 0;
    int upd_n = 0;
    lep_fl_source i_lep_fl_source (.*);
    lep_parser i_lep_parser (.*);
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // private bytes and logon updates seen at the port
    always @(posedge clock)
    begin
        if (priv_valid === 1'b1) priv_n <= priv_n + 1;
        if (logon_update === 1'b1) upd_n <= upd_n + 1;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one transfer, held until waitrequest is low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            fail_count++;
            end_of_test();
        end
        @(posedge clock);
    endtask : bus
    // tag, length, body; no reserved bits to fill
    task automatic send(input logic [7:0] tg, input logic sec,
                        input logic fst, input logic [7:0] b[$]);
        i_lep_fl_source.push({sec, fst, tg});
        i_lep_fl_source.push({sec, 1'b0, 8'(b.size())});
        foreach (b[k])
            i_lep_fl_source.push({sec, 1'b0, b[k]});
    endtask : send
    // answers land within two cycles
    task automatic drain;
        int n;
        n = 0;
        while (i_lep_fl_source.q.size() != 0 && n < 500)
        begin
            @(posedge clock);
            n++;
        end
        if (n == 500)
        begin
            fail_count++;
            end_of_test();
        end
        repeat (4) @(posedge clock);
    endtask : drain
    task automatic tick(input logic [15:0] c);
        sf_count <= c;
        sf_tick <= 1'b1;
        @(posedge clock);
        sf_tick <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : tick
    task automatic sc_regs;
        bus(0, lep_pkg::REG_CTRL, 0);
        chk(rd, lep_pkg::CTRL_RST);
        bus(0, lep_pkg::REG_POP, 0);
        chk(rd, lep_pkg::POP_RST);
        bus(0, lep_pkg::REG_STATUS, 0);
        chk(rd, 32'h0000_0000);
        bus(1, lep_pkg::REG_ECHO, 32'h0000_FFFF);
        bus(0, lep_pkg::REG_ECHO, 0);
        chk(rd, 32'h0000_0000);
        bus(0, 6'h3C, 0);
        chk(rd, 32'h0000_0000);
    endtask : sc_regs
    // unknown tag hiding an echo, then a real echo
    task automatic sc_echo;
        send(8'h55, 1'b0, 1'b1, '{8'hA1, 8'h02, 8'hFF});
        send(8'hA1, 1'b0, 1'b0, '{8'h8A, 8'hBC});
        drain();
        chk(echo_word, 32'h8ABC);
        chk(echo_pending, 1);
        bus(0, lep_pkg::REG_ECHO, 0);
        chk(rd[15:0], 32'h8ABC);
        echo_ack <= 1'b1;
        @(posedge clock);
        echo_ack <= 1'b0;
        repeat (2) @(posedge clock);
        chk(echo_pending, 0);
    endtask : sc_echo
    // unkeyed list, then two ids plus a stray third
    task automatic sc_logon;
        send(8'hA0, 1'b0, 1'b0, '{0, 8'h0F, 0, 1, 0, 8'h77, 8'h77});
        drain();
        chk(logon_armed, 0);
        send(8'hA0, 1'b1, 1'b0, '{0, 8'h10, 0, 8'h03, 8'h01, 8'h11, 8'h11,
            8'h22, 8'h22, 8'h33, 8'h33});
        drain();
        chk(logon_armed, 1);
        tick(16'h000F);
        chk(logon_id, 0);
        tick(16'h0010);
        chk(logon_id, 32'h1111);
        tick(16'h0012);
        chk(logon_id, 32'h1111);
        tick(16'h0013);
        chk(logon_id, 32'h2222);
        chk(logon_armed, 0);
        tick(16'h0016);
        chk(logon_id, 32'h2222);
        chk(upd_n, 2);
    endtask : sc_logon
    // two ranges, second hits; slow sender
    task automatic sc_link;
        bus(1, lep_pkg::REG_POP, 32'h0000_1234);
        i_lep_fl_source.slow = 1'b1;
        send(8'hA2, 1'b0, 1'b1, '{1, 1, 2, 2, 3, 3, 8'h81, 8'h55, 8'h66, 1,
            8'hFF, 8'hFF, 0, 0, 8'h12, 0, 0, 8'hFF, 8'hC1, 8'hC2});
        drain();
        chk(net_match, 1);
        chk(net_label, 32'h5566);
        chk(priv_n, 2);
        chk(priv_data, 32'hC2);
        bus(0, lep_pkg::REG_TSON, 0);
        chk(rd, 32'h0101_0202);
        bus(0, lep_pkg::REG_SVNET, 0);
        chk(rd, 32'h0303_5566);
        bus(0, lep_pkg::REG_MATCH, 0);
        chk(rd, 32'h0002_5566);
        bus(0, lep_pkg::REG_STATUS, 0);
        chk(rd, 32'h0000_0003);
        send(8'hA2, 1'b0, 1'b1, '{1, 1, 2, 2, 3, 3, 8'h80, 8'h55, 8'h66, 0,
            8'h12, 8'h34, 0, 0, 8'hC3});
        drain();
        i_lep_fl_source.slow = 1'b0;
        chk(net_match, 0);
        chk(priv_n, 2);
    endtask : sc_link
    // a disabled walker ignores the stream
    task automatic sc_off;
        bus(1, lep_pkg::REG_CTRL, 0);
        send(8'hA1, 1'b0, 1'b1, '{8'h80, 8'h01});
        drain();
        chk(echo_word, 32'h8ABC);
        bus(1, lep_pkg::REG_CTRL, 1);
    endtask : sc_off
    initial
    begin
        sys_rst = 1'b1;
        {avs_read, avs_write, sf_tick, echo_ack} = 4'h0;
        avs_address = 6'h00;
        avs_writedata = 32'h0000_0000;
        sf_count = 16'h0000;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        sc_regs();
        sc_echo();
        sc_logon();
        sc_link();
        sc_off();
        end_of_test();
    end
endmodule : lep_parser_test
bind lep_parser lep_parser_monitor i_lep_parser_monitor (.*);
